// ### rtl/tsd_descrambler.sv
// tsd_descrambler: realigns a pseudo-random sequence on inverted sync bytes
// assumes upstream gives bytes with a valid strobe, sync bytes at packet start
// How it works
// RULE1: sequence comes from a 15 stage register, polynomial 1 + x^14 + x^15.
// RULE2: stages 1..15 load 1,0,0,1,0,1,0,1,0,0,0,0,0,0,0 at every restart.
// RULE3: the alignment marker is sync byte B8, the inverse of 47.
// RULE4: first fresh sequence bit hits the first data bit after the marker.
// RULE5: normal sync bytes pass unchanged while the generator keeps stepping.
// RULE6: the generator reloads its start pattern after every inverted sync byte.
// RULE7: data bits xor with sequence bits, msb first, one step per bit.
`timescale 1ns/10ps
`default_nettype none
module tsd_descrambler
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire tsd_pkg::tsd_byte_t inByte,
    input wire logic inSync,
    output tsd_pkg::tsd_byte_t outByte,
    output logic outAligned
);
    import tsd_pkg::*;

    tsd_state_t state;
    tsd_state_t next_state;
    logic [14:0] prbs;
    logic [14:0] next_prbs;
    logic [14:0] stepped;
    logic [7:0] mask;
    tsd_byte_t next_outByte;
    logic next_outAligned;

    // one pattern test serves the marker decode and the normal sync decode
    function automatic logic sync_is
    (
        input tsd_byte_t b,
        input logic atSync,
        input logic [7:0] pattern
    );
        return b.valid && atSync && (b.data == pattern);
    endfunction : sync_is

    // inSync flags a byte at the packet sync position
    wire isMarker = sync_is(inByte, inSync, SYNC_INVERTED); // [RULE3]
    wire isNormalSync = sync_is(inByte, inSync, SYNC_NORMAL);
    wire isData = inByte.valid && !inSync;

    tsd_prbs_byte u_step
    (
        .state(prbs),
        .mask(mask),
        .stateOut(stepped)
    );

    // marker reloads the seed so the next data bit gets the first output [RULE2] [RULE4] [RULE6]
    // normal syncs still step the generator, they are merely not modified [RULE5]
    assign next_prbs = isMarker ? PRBS_SEED : (inByte.valid ? stepped : prbs);
    assign next_state = isMarker ? TSD_RUN : state;

    // until the first marker, data passes through; no alignment is known yet
    wire applyMask = isData && (state == TSD_RUN);
    wire [7:0] next_data = applyMask ? (inByte.data ^ mask) : inByte.data; // [RULE7]
    assign next_outByte = '{valid: inByte.valid, data: next_data};
    assign next_outAligned = (next_state == TSD_RUN);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= TSD_HUNT;
            prbs <= PRBS_SEED; // [RULE2]
        end
        else
        begin
            state <= next_state;
            prbs <= next_prbs;
        end
    end

    // outputs sit in their own registers so the pins never see the decode ripple
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            outByte <= '0;
        end
        else
        begin
            outByte <= next_outByte;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            outAligned <= 1'b0;
        end
        else
        begin
            outAligned <= next_outAligned;
        end
    end

    // the first sequence bit after a marker, worked from the seed alone
    wire firstSeqBit = PRBS_SEED[TAP_A] ^ PRBS_SEED[TAP_B];

    // a marker with a data byte straight behind it, no idle cycle between
    sequence seq_marker_then_data;
        isMarker ##1 isData;
    endsequence

    property p_reload;
        @(posedge sys_clk) disable iff (reset)
        isMarker |=> (prbs == PRBS_SEED);
    endproperty

    AST_RELOAD: assert property (p_reload) // [RULE6]
        else $error("generator not reloaded after marker");

    property p_sync_pass;
        @(posedge sys_clk) disable iff (reset)
        inByte.valid && inSync |=> (outByte.data == $past(inByte.data));
    endproperty

    AST_SYNC_PASS: assert property (p_sync_pass) // [RULE5]
        else $error("sync byte modified");

    property p_step_on_sync;
        @(posedge sys_clk) disable iff (reset)
        isNormalSync && state == TSD_RUN |=> (prbs == $past(stepped));
    endproperty

    AST_STEP_ON_SYNC: assert property (p_step_on_sync) // [RULE5]
        else $error("generator stalled on normal sync");

    property p_first_bit;
        @(posedge sys_clk) disable iff (reset)
        seq_marker_then_data |=> (outByte.data[7] == ($past(inByte.data[7]) ^ firstSeqBit));
    endproperty

    AST_FIRST_BIT: assert property (p_first_bit) // [RULE4]
        else $error("first data bit not matched to first sequence bit");

    property p_xor;
        @(posedge sys_clk) disable iff (reset)
        applyMask |=> (outByte.data == ($past(inByte.data) ^ $past(mask)));
    endproperty

    AST_XOR: assert property (p_xor) // [RULE7]
        else $error("data not combined with sequence");

    property p_feedback;
        @(posedge sys_clk) disable iff (reset)
        mask[BYTE_BITS - 1] == (prbs[TAP_A] ^ prbs[TAP_B]);
    endproperty

    AST_FEEDBACK: assert property (p_feedback) // [RULE1]
        else $error("feedback taps wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (reset)
        !inByte.valid |=> $stable(prbs);
    endproperty

    AST_HOLD: assert property (p_hold) // [RULE7]
        else $error("generator moved without data");

    property p_marker_align;
        @(posedge sys_clk) disable iff (reset)
        isMarker |=> outAligned && (outByte.data == SYNC_INVERTED);
    endproperty

    AST_MARKER_ALIGN: assert property (p_marker_align) // [RULE3]
        else $error("marker not recognised");

    property p_valid_pipe;
        @(posedge sys_clk) disable iff (reset)
        inByte.valid |=> outByte.valid;
    endproperty

    AST_VALID_PIPE: assert property (p_valid_pipe) // [RULE7]
        else $error("byte lost on its way out");

    property p_idle_pipe;
        @(posedge sys_clk) disable iff (reset)
        !inByte.valid |=> !outByte.valid;
    endproperty

    AST_IDLE_PIPE: assert property (p_idle_pipe) // [RULE7]
        else $error("output valid without an input byte");

    property p_hunt_pass;
        @(posedge sys_clk) disable iff (reset)
        isData && state == TSD_HUNT |=> (outByte.data == $past(inByte.data));
    endproperty

    AST_HUNT_PASS: assert property (p_hunt_pass) // [RULE4]
        else $error("data modified before the first marker");

    property p_align_hold;
        @(posedge sys_clk) disable iff (reset)
        outAligned |=> outAligned;
    endproperty

    AST_ALIGN_HOLD: assert property (p_align_hold) // [RULE6]
        else $error("alignment dropped without reset");

    property p_data_step;
        @(posedge sys_clk) disable iff (reset)
        isData |=> (prbs == $past(stepped));
    endproperty

    AST_DATA_STEP: assert property (p_data_step) // [RULE7]
        else $error("data byte did not step the generator");

    property p_no_early_align;
        @(posedge sys_clk) disable iff (reset)
        !outAligned && !isMarker |=> !outAligned;
    endproperty

    AST_NO_EARLY_ALIGN: assert property (p_no_early_align) // [RULE3]
        else $error("aligned without a marker");
endmodule : tsd_descrambler
`default_nettype wire

// ### rtl/tsd_pkg.sv
// tsd_pkg: constants and carrier types for the transport stream descrambler
// assumes a byte stream with a valid strobe, one byte per cycle at most
package tsd_pkg;
    localparam int PRBS_LEN = 15;
    localparam logic [14:0] PRBS_SEED = 15'h00A9; // stages 1..15 = 100101010000000, stage1 in bit0
    localparam int TAP_A = 13; // stage 14
    localparam int TAP_B = 14; // stage 15
    localparam logic [7:0] SYNC_NORMAL = 8'h47;
    localparam logic [7:0] SYNC_INVERTED = 8'hB8;
    localparam int BYTE_BITS = 8;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tsd_byte_t;

    typedef enum logic [1:0] {
        TSD_HUNT = 2'b00,
        TSD_RUN = 2'b01
    } tsd_state_t;
endpackage : tsd_pkg

// ### rtl/tsd_prbs_byte.sv
// tsd_prbs_byte: combinational eight-step advance of the sequence generator
// assumes the caller registers the state; bit0 of state is stage 1
`timescale 1ns/10ps
`default_nettype none
module tsd_prbs_byte
(
    input wire logic [14:0] state,
    output logic [7:0] mask,
    output logic [14:0] stateOut
);
    import tsd_pkg::*;

    logic [14:0] chain [0:8];
    assign chain[0] = state;

    genvar i;
    generate
        for (i = 0; i < BYTE_BITS; i++)
        begin : g_step
            wire fb = chain[i][TAP_A] ^ chain[i][TAP_B]; // [RULE1]
            // msb of the byte meets the first generated bit [RULE7]
            assign mask[BYTE_BITS - 1 - i] = fb;
            assign chain[i + 1] = {chain[i][13:0], fb};
        end
    endgenerate

    assign stateOut = chain[BYTE_BITS];
endmodule : tsd_prbs_byte
`default_nettype wire

// ### dv/tsd_src.sv
// tsd_src: upstream block decoder stage, one byte per send call
// assumes a single calling process
`timescale 1ns/10ps
`default_nettype none
module tsd_src
(
    input wire logic clk,
    output tsd_pkg::tsd_byte_t inByte = '0,
    output logic inSync = 1'b0
);
    import tsd_pkg::*;
    task send(input logic [7:0] d, input logic s);
        @(posedge clk);
        inByte <= '{1'b1, d};
        inSync <= s;
        @(posedge clk);
        inByte.valid <= 1'b0;
        // data is dead once valid drops, so invert it rather than hold it
        inByte.data <= ~d;
        inSync <= 1'b0;
    endtask : send
    // two bytes on consecutive edges, valid held high across the seam
    task send_pair(input logic [7:0] d0, input logic s0, input logic [7:0] d1, input logic s1);
        @(posedge clk);
        inByte <= '{1'b1, d0};
        inSync <= s0;
        @(posedge clk);
        inByte <= '{1'b1, d1};
        inSync <= s1;
        @(posedge clk);
        inByte.valid <= 1'b0;
        inByte.data <= ~d1;
        inSync <= 1'b0;
    endtask : send_pair
endmodule : tsd_src
`default_nettype wire

// ### dv/transport_stream_descrambler_tb.sv
// transport_stream_descrambler_tb: row driven check of the descrambler
// assumes tsd_src as upstream stage; expectations come from a local generator
`timescale 1ns/10ps
`default_nettype none
module transport_stream_descrambler_tb;
    import tsd_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    tsd_byte_t inByte, outByte;
    logic inSync, outAligned;
    int bad_count = 0, n_tests = 0, cyc = 0;
    logic [14:0] st = PRBS_SEED;
    // {aligned after, sync, byte}; a plain B8 data byte must not realign
    logic [9:0] rows [10] = '{10'h012, 10'h147, 10'h3B8, 10'h200, 10'h2FF,
        10'h347, 10'h25A, 10'h3B8, 10'h200, 10'h2B8};
    initial forever #5 sys_clk = ~sys_clk;
    tsd_src src (.clk(sys_clk), .inByte(inByte), .inSync(inSync));
    tsd_descrambler uut (.sys_clk(sys_clk), .reset(reset), .inByte(inByte),
        .inSync(inSync), .outByte(outByte), .outAligned(outAligned));
    task check(input logic [9:0] seen, input logic [9:0] want);
        n_tests++;
        if (seen !== want)
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        if (seen !== want)
            bad_count++;
    endtask : check
    task wrap_up;
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // local model of the generator: eight steps, first step on the msb
    task advance(output logic [7:0] mk);
        for (int b = 7; b >= 0; b--)
        begin
            mk[b] = st[TAP_A] ^ st[TAP_B];
            st = {st[13:0], mk[b]};
        end
    endtask : advance
    initial
    begin
        logic [7:0] e, m;
        logic al;
        al = 1'b0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        #1 check({outAligned, outByte}, 10'h000);
        foreach (rows[i])
        begin
            advance(m);
            e = (al && !rows[i][8]) ? rows[i][7:0] ^ m : rows[i][7:0];
            if (rows[i][8] && rows[i][7:0] == SYNC_INVERTED)
                st = PRBS_SEED;
            al = rows[i][9];
            src.send(rows[i][7:0], rows[i][8]);
            #1 check({outAligned, outByte}, {al, 1'b1, e});
        end
        // mid-run reset drops alignment; the next data byte passes untouched
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1 check({outAligned, outByte}, 10'h000);
        src.send(8'h3C, 1'b0);
        #1 check({outAligned, outByte}, 10'h13C);
        // marker and data on consecutive edges, no idle cycle to hide behind
        fork
            src.send_pair(SYNC_INVERTED, 1'b1, 8'h80, 1'b0);
            begin
                repeat (2) @(posedge sys_clk);
                #1 check({outAligned, outByte}, {2'b11, SYNC_INVERTED});
            end
        join
        st = PRBS_SEED;
        advance(m);
        #1 check({outAligned, outByte}, {2'b11, 8'h80 ^ m});
        @(posedge sys_clk);
        #1 check({outAligned, outByte.valid, 8'h00}, 10'h200);
        wrap_up();
    end
endmodule : transport_stream_descrambler_tb
`default_nettype wire
